// ### async_serial_receiver.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_rx_map.svh"

module async_serial_receiver (
	// clock, reset, enable
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// serial line
	input  wire logic        serial_in_pin,
	// serial clock pin
	input  wire logic        serial_clk_pin_in,
	output logic             serial_clk_pin_out,
	output logic             serial_clk_pin_oe
);

	////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]                port_control_reg;
	logic [7:0]                frame_format_reg;
	logic [7:0]                bit_rate_divisor;
	logic [7:0]                serial_control_reg;
	logic [7:0]                rx_holding;
	logic [7:0]                rx_shifter;
	logic [3:0]                flags;
	logic [3:0]                seen;
	logic [3:0]                set_ev;
	logic [3:0]                clr_ev;
	logic                      mpb_received;

	// bus
	logic                      acc;
	logic                      hit;
	logic [15:0]               idx;
	logic                      wr_pend;
	logic [15:0]               wr_idx;
	logic                      wr_now;
	logic                      rd_status;
	logic                      wr_status;

	// baud
	logic [5:0]                pre_cnt;
	logic [5:0]                pre_lim;
	logic                      pre_tick;
	logic [7:0]                div_cnt;
	logic [1:0]                quarter;
	logic                      os_tick;
	logic [3:0]                os_phase;

	// receiver
	serial_rx_pkg::rx_state_t  state;
	logic [3:0]                sample_cnt;
	logic [2:0]                bit_idx;
	logic [2:0]                last_bit;
	logic                      par_acc;
	logic                      extra_bit;
	logic                      rx_in;
	logic                      rx_run;
	logic                      sample_now;
	logic                      complete;
	logic                      need_extra;

	////////////////////////////////////////////////////////////////
	// bus decode
	assign hreadyout = ce;
	assign hresp     = 1'b0;
	assign idx       = haddr[17:2];
	assign hit       = (haddr[31:18] == 14'h0000);
	assign acc       = hsel & hready & htrans[1] & ce;
	assign wr_now    = wr_pend & ce;
	assign rd_status = acc & ~hwrite & hit & (idx == `IDX_SER_STATUS);
	assign wr_status = wr_now & (wr_idx == `IDX_SER_STATUS);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_idx  <= 16'h0000;
		end else if (ce) begin
			wr_pend <= acc & hwrite & hit;
			wr_idx  <= idx;
		end
	end

	function automatic logic [7:0] read_mux(input logic [15:0] a);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			`IDX_PORT_CTRL:  r = port_control_reg;
			`IDX_FRAME_FMT:  r = frame_format_reg;
			`IDX_BIT_DIV:    r = bit_rate_divisor;
			`IDX_SER_CTRL:   r = serial_control_reg;
			`IDX_SER_STATUS: r = {1'b0, flags, 1'b0, mpb_received, 1'b0};
			`IDX_RX_HOLD:    r = rx_holding;
			default:         r = 8'h00;
		endcase
		return r;
	endfunction

	// read data registered at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (acc & ~hwrite) begin
			hrdata <= hit ? {24'h00_0000, read_mux(idx)} : 32'h0000_0000;
		end
	end

	// writable registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_control_reg   <= `RST_REG8;
			frame_format_reg   <= `RST_REG8;
			bit_rate_divisor   <= `RST_REG8;
			serial_control_reg <= `RST_REG8;
		end else if (wr_now) begin
			case (wr_idx)
				`IDX_PORT_CTRL: port_control_reg   <= hwdata[7:0];
				`IDX_FRAME_FMT: frame_format_reg   <= hwdata[7:0];
				`IDX_BIT_DIV:   bit_rate_divisor   <= hwdata[7:0];
				`IDX_SER_CTRL:  serial_control_reg <= hwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// status flags: bit order full, overrun, frame, parity
	assign set_ev[3] = complete & ~flags[3];
	assign set_ev[2] = complete & flags[3];
	assign set_ev[1] = complete & ~rx_in;
	assign set_ev[0] = complete & frame_format_reg[`FMT_PARITY_ON]
		& ~frame_format_reg[`FMT_MULTIPROC]
		& (par_acc ^ extra_bit ^ frame_format_reg[`FMT_PARITY_ODD]);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_flag
			// clear only after the flag was seen as 1 and a 0 is written
			assign clr_ev[gi] = wr_status & seen[gi] & ~hwdata[`STS_PARITY + gi];

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					flags[gi] <= 1'b0;
				end else if (ce) begin
					if (set_ev[gi]) begin
						flags[gi] <= 1'b1;
					end else if (clr_ev[gi]) begin
						flags[gi] <= 1'b0;
					end
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					seen[gi] <= 1'b0;
				end else if (rd_status) begin
					seen[gi] <= flags[gi];
				end else if (wr_status) begin
					seen[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// baud generator, 16 ticks per bit
	always_comb begin
		case ({frame_format_reg[`FMT_PRESCALE_HI], frame_format_reg[`FMT_PRESCALE_LO]})
			2'b00:   pre_lim = `PRE_LIM0;
			2'b01:   pre_lim = `PRE_LIM1;
			2'b10:   pre_lim = `PRE_LIM2;
			default: pre_lim = `PRE_LIM3;
		endcase
	end

	// wrap at or above the limit so a lowered divisor or prescale takes at once
	assign pre_tick = (pre_cnt >= pre_lim);
	assign os_tick  = pre_tick & (div_cnt >= bit_rate_divisor)
		& (quarter == `OS_QUARTER_LAST);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_cnt <= 6'h00;
			div_cnt <= 8'h00;
			quarter <= 2'h0;
		end else if (ce) begin
			pre_cnt <= pre_tick ? 6'h00 : pre_cnt + 6'h01;
			if (pre_tick) begin
				div_cnt <= (div_cnt >= bit_rate_divisor) ? 8'h00 : div_cnt + 8'h01;
				if (div_cnt >= bit_rate_divisor) begin
					quarter <= quarter + 2'h1;
				end
			end
		end
	end

	// bit-rate phase for the optional clock output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			os_phase <= 4'h0;
		end else if (ce & os_tick) begin
			os_phase <= os_phase + 4'h1;
		end
	end

	// clock pin: only driven when async clock output is selected
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_clk_pin_oe  <= 1'b0;
			serial_clk_pin_out <= 1'b0;
		end else if (ce) begin
			serial_clk_pin_oe  <= ~frame_format_reg[`FMT_SYNC_MODE]
				& ~serial_control_reg[`CTL_CLK_CFG_HI]
				& serial_control_reg[`CTL_CLK_CFG_LO];
			serial_clk_pin_out <= os_phase[3];
		end
	end

	////////////////////////////////////////////////////////////////
	// receiver
	assign rx_in      = serial_in_pin ^ port_control_reg[`PCR_RX_INVERT];
	assign rx_run     = serial_control_reg[`CTL_RX_ON]
		& ~frame_format_reg[`FMT_SYNC_MODE];
	assign sample_now = ce & os_tick & (sample_cnt == `OS_SAMPLE);
	assign complete   = sample_now & (state == serial_rx_pkg::st_stop1) & rx_run;
	assign last_bit   = frame_format_reg[`FMT_SEVEN_BIT] ? 3'h6 : 3'h7;
	assign need_extra = frame_format_reg[`FMT_PARITY_ON]
		| frame_format_reg[`FMT_MULTIPROC];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= serial_rx_pkg::st_idle;
		end else if (ce) begin
			if (!rx_run) begin
				state <= serial_rx_pkg::st_idle;
			end else begin
				case (state)
					serial_rx_pkg::st_idle: begin
						if (os_tick & ~rx_in) begin
							state <= serial_rx_pkg::st_start;
						end
					end
					serial_rx_pkg::st_start: begin
						if (sample_now) begin
							state <= rx_in ? serial_rx_pkg::st_idle : serial_rx_pkg::st_data;
						end
					end
					serial_rx_pkg::st_data: begin
						if (sample_now & (bit_idx == last_bit)) begin
							state <= need_extra ? serial_rx_pkg::st_extra : serial_rx_pkg::st_stop1;
						end
					end
					serial_rx_pkg::st_extra: begin
						if (sample_now) begin
							state <= serial_rx_pkg::st_stop1;
						end
					end
					serial_rx_pkg::st_stop1: begin
						if (sample_now) begin
							state <= frame_format_reg[`FMT_TWO_STOP] ? serial_rx_pkg::st_stop2
								: serial_rx_pkg::st_idle;
						end
					end
					serial_rx_pkg::st_stop2: begin
						if (sample_now) begin
							state <= serial_rx_pkg::st_idle;
						end
					end
					default: state <= serial_rx_pkg::st_idle;
				endcase
			end
		end
	end

	// oversample counter restarts on each start edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sample_cnt <= 4'h0;
		end else if (ce) begin
			if (state == serial_rx_pkg::st_idle) begin
				sample_cnt <= 4'h0;
			end else if (os_tick) begin
				sample_cnt <= sample_cnt + 4'h1;
			end
		end
	end

	// data bits, lsb first, into the private shifter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_shifter <= 8'h00;
			bit_idx    <= 3'h0;
			par_acc    <= 1'b0;
		end else if (sample_now) begin
			if (state == serial_rx_pkg::st_start) begin
				rx_shifter <= 8'h00;
				bit_idx    <= 3'h0;
				par_acc    <= 1'b0;
			end else if (state == serial_rx_pkg::st_data) begin
				rx_shifter[bit_idx] <= rx_in;
				bit_idx             <= bit_idx + 3'h1;
				par_acc             <= par_acc ^ rx_in;
			end
		end
	end

	// parity or multiprocessor bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			extra_bit <= 1'b0;
		end else if (sample_now) begin
			if (state == serial_rx_pkg::st_start) begin
				extra_bit <= 1'b0;
			end else if (state == serial_rx_pkg::st_extra) begin
				extra_bit <= rx_in;
			end
		end
	end

	// transfer to holding register unless still full
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_holding   <= `RST_REG8;
			mpb_received <= 1'b0;
		end else if (complete & ~flags[3]) begin
			rx_holding   <= rx_shifter;
			mpb_received <= frame_format_reg[`FMT_MULTIPROC] & extra_bit;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	full_set_a: assert property (complete & ~flags[3] |=> flags[3]) else $error("full flag not set");
	hold_load_a: assert property (complete & ~flags[3] |=> rx_holding == $past(rx_shifter))
		else $error("holding not loaded");
	overrun_keep_a: assert property (complete & flags[3] |=> flags[2] & $stable(rx_holding))
		else $error("overrun mishandled");
	frame_err_a: assert property (complete & ~rx_in |=> flags[1]) else $error("frame error missed");
	parity_err_a: assert property (complete & frame_format_reg[`FMT_PARITY_ON]
		& ~frame_format_reg[`FMT_MULTIPROC] & ~(par_acc ^ extra_bit ^ frame_format_reg[`FMT_PARITY_ODD])
		& ~flags[0] & ~clr_ev[0] |=> ~flags[0]) else $error("false parity error");
	rx_off_a: assert property (ce & ~serial_control_reg[`CTL_RX_ON] |=> state == serial_rx_pkg::st_idle)
		else $error("receiver ran while off");
	mid_sample_a: assert property ((state == serial_rx_pkg::st_start) ##1 (state == serial_rx_pkg::st_data)
		|-> $past(os_tick & (sample_cnt == 4'h7))) else $error("start left off mid-cell");
	no_set_a: assert property (wr_status & ~flags[3] & ~complete |=> ~flags[3])
		else $error("flag set by write");
	clk_pin_a: assert property (ce & (serial_control_reg[1:0] == 2'b00) |=> ~serial_clk_pin_oe)
		else $error("clock pin driven");

endmodule

`default_nettype wire

// ### serial_rx_map.svh
`ifndef SERIAL_RX_MAP_SVH
`define SERIAL_RX_MAP_SVH

// register indices, byte address is four times the index
`define IDX_PORT_CTRL    16'hff91
`define IDX_FRAME_FMT    16'hffa8
`define IDX_BIT_DIV      16'hffa9
`define IDX_SER_CTRL     16'hffaa
`define IDX_SER_STATUS   16'hffac
`define IDX_RX_HOLD      16'hffad

// frame format fields
`define FMT_SYNC_MODE    7
`define FMT_SEVEN_BIT    6
`define FMT_PARITY_ON    5
`define FMT_PARITY_ODD   4
`define FMT_TWO_STOP     3
`define FMT_MULTIPROC    2
`define FMT_PRESCALE_HI  1
`define FMT_PRESCALE_LO  0

// serial control fields
`define CTL_RX_ON        4
`define CTL_CLK_CFG_HI   1
`define CTL_CLK_CFG_LO   0

// status fields
`define STS_RX_FULL      6
`define STS_OVERRUN      5
`define STS_FRAME        4
`define STS_PARITY       3
`define STS_MPB          1

// port control fields
`define PCR_RX_INVERT    2

// reset values
`define RST_REG8         8'h00

// prescaler terminal counts for select 0..3
`define PRE_LIM0         6'h00
`define PRE_LIM1         6'h03
`define PRE_LIM2         6'h0f
`define PRE_LIM3         6'h3f

// oversampling: 16 ticks a bit, sample at mid-cell
`define OS_SAMPLE        4'h7
`define OS_QUARTER_LAST  2'h3

`endif

// ### serial_rx_pkg.sv
package serial_rx_pkg;
	typedef enum logic [2:0] {
		st_idle,
		st_start,
		st_data,
		st_extra,
		st_stop1,
		st_stop2
	} rx_state_t;
endpackage

// ### serial_tx_model.sv
`timescale 1ns/1ps
`default_nettype none

module serial_tx_model (
	// clock
	input  wire logic hclk,
	// serial line
	output logic      line
);
	logic idle_lvl = 1'b1;

	initial line = 1'b1;

	////////////////////////////////////////////////
	// idle level, low when the receiver inverts
	task automatic set_idle(input logic v);
		idle_lvl = v;
		line <= v;
	endtask

	// one frame; sv is the level of the last stop bit
	task automatic send(input logic [7:0] d, input int nb, input int clks, input logic hx,
		input logic x, input int ns, input logic sv);
		logic [12:0] fr;
		int          n;
		fr = '1;
		fr[0] = 1'b0; // start low
		for (int i = 0; i < nb; i++) begin
			fr[1 + i] = d[i]; // lsb first
		end
		n = nb + 1;
		if (hx) begin
			fr[n] = x; // parity or address bit
			n++;
		end
		n = n + ns;
		fr[n - 1] = sv;
		for (int i = 0; i < n; i++) begin
			line <= fr[i] ^ ~idle_lvl;
			repeat (clks) @(posedge hclk);
		end
		line <= idle_lvl; // idle between frames
	endtask
endmodule

`default_nettype wire

// ### test_async_serial_receiver.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_rx_map.svh"

module test_async_serial_receiver;
	logic        hclk    = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel    = 1'b0;
	logic [31:0] haddr   = 32'h0000_0000;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic [31:0] hwdata  = 32'h0000_0000;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        line;
	logic        clk_oe;
	logic        clk_out;
	logic        clk_was;
	logic        ce      = 1'b1;
	logic [31:0] rd;
	int          fails   = 0;
	int          n_tests = 0;
	int          cycles  = 0;

	async_serial_receiver DUT (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .serial_in_pin(line), .serial_clk_pin_in(1'b0),
		.serial_clk_pin_out(clk_out), .serial_clk_pin_oe(clk_oe)
	);

	serial_tx_model tx (.hclk(hclk), .line(line));

	always #20 hclk = ~hclk;

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			summarize();
		end
	end

	////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// single ahb transfer, waits on hready in both phases
	task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
		hsel <= 1'b1;
		haddr <= {14'h0000, idx, 2'b00};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h00_0000, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic expect_reg(input logic [15:0] idx, input string what, input logic [7:0] exp);
		bus(idx, 1'b0, 8'h00);
		check(what, exp, rd[7:0]);
	endtask

	task automatic clear_flags();
		bus(`IDX_SER_STATUS, 1'b0, 8'h00);
		bus(`IDX_SER_STATUS, 1'b1, 8'h00);
	endtask

	task automatic setup(input logic [7:0] fmt, input logic [7:0] div, input logic [7:0] ctl);
		bus(`IDX_SER_CTRL, 1'b1, 8'h00);
		bus(`IDX_FRAME_FMT, 1'b1, fmt);
		bus(`IDX_BIT_DIV, 1'b1, div);
		bus(`IDX_SER_CTRL, 1'b1, ctl);
	endtask

	////////////////////////////////////////////////
	task automatic t_regs();
		expect_reg(`IDX_PORT_CTRL, "port ctrl", 8'h00);
		expect_reg(`IDX_FRAME_FMT, "format", 8'h00);
		expect_reg(`IDX_BIT_DIV, "divisor", 8'h00);
		expect_reg(`IDX_SER_CTRL, "control", 8'h00);
		expect_reg(`IDX_SER_STATUS, "status", 8'h00);
		expect_reg(`IDX_RX_HOLD, "holding", 8'h00);
		check("resp", 8'h00, {7'h00, hresp});
		bus(`IDX_FRAME_FMT, 1'b1, 8'h5a);
		expect_reg(`IDX_FRAME_FMT, "format", 8'h5a);
		bus(`IDX_RX_HOLD, 1'b1, 8'hff);
		expect_reg(`IDX_RX_HOLD, "holding ro", 8'h00);
		bus(16'hff00, 1'b1, 8'hff);
		expect_reg(16'hff00, "unmapped", 8'h00);
	endtask

	task automatic t_basic();
		setup(8'h00, 8'h00, 8'h10);
		tx.send(8'ha5, 8, 64, 1'b0, 1'b0, 1, 1'b1);
		expect_reg(`IDX_SER_STATUS, "status", 8'h40);
		expect_reg(`IDX_RX_HOLD, "holding", 8'ha5);
		bus(`IDX_SER_STATUS, 1'b1, 8'h78);
		expect_reg(`IDX_SER_STATUS, "status w1", 8'h40);
		clear_flags();
		expect_reg(`IDX_SER_STATUS, "status clr", 8'h00);
		bus(`IDX_SER_STATUS, 1'b1, 8'h78);
		expect_reg(`IDX_SER_STATUS, "status set", 8'h00);
	endtask

	task automatic t_overrun();
		tx.send(8'h5a, 8, 64, 1'b0, 1'b0, 1, 1'b1);
		tx.send(8'h3c, 8, 64, 1'b0, 1'b0, 1, 1'b1);
		expect_reg(`IDX_SER_STATUS, "status", 8'h60);
		expect_reg(`IDX_RX_HOLD, "holding", 8'h5a);
		clear_flags();
		tx.send(8'h96, 8, 64, 1'b0, 1'b0, 1, 1'b0);
		expect_reg(`IDX_SER_STATUS, "status", 8'h50);
		expect_reg(`IDX_RX_HOLD, "holding", 8'h96);
		clear_flags();
	endtask

	task automatic t_format();
		setup(8'h20, 8'h00, 8'h10);
		tx.send(8'ha5, 8, 64, 1'b1, 1'b0, 1, 1'b1);
		expect_reg(`IDX_SER_STATUS, "even", 8'h40);
		clear_flags();
		setup(8'h30, 8'h00, 8'h10);
		tx.send(8'ha5, 8, 64, 1'b1, 1'b0, 1, 1'b1);
		expect_reg(`IDX_SER_STATUS, "odd", 8'h48);
		clear_flags();
		setup(8'h40, 8'h00, 8'h10);
		tx.send(8'hd5, 7, 64, 1'b0, 1'b0, 1, 1'b1);
		expect_reg(`IDX_RX_HOLD, "seven", 8'h55);
		clear_flags();
		setup(8'h04, 8'h00, 8'h10);
		tx.send(8'h69, 8, 64, 1'b1, 1'b1, 1, 1'b1);
		expect_reg(`IDX_SER_STATUS, "mp", 8'h42);
		clear_flags();
		setup(8'h08, 8'h00, 8'h10);
		tx.send(8'h3c, 8, 64, 1'b0, 1'b0, 2, 1'b0);
		repeat (704) @(posedge hclk);
		expect_reg(`IDX_SER_STATUS, "two stop", 8'h40);
		expect_reg(`IDX_RX_HOLD, "two stop", 8'h3c);
		clear_flags();
	endtask

	task automatic t_off();
		setup(8'h00, 8'h00, 8'h00);
		tx.send(8'h11, 8, 64, 1'b0, 1'b0, 1, 1'b1);
		expect_reg(`IDX_SER_STATUS, "rx off", 8'h00);
		setup(8'h80, 8'h00, 8'h10);
		tx.send(8'h22, 8, 64, 1'b0, 1'b0, 1, 1'b1);
		expect_reg(`IDX_SER_STATUS, "sync", 8'h00);
	endtask

	task automatic t_invert();
		setup(8'h00, 8'h00, 8'h00);
		bus(`IDX_PORT_CTRL, 1'b1, 8'h04);
		tx.set_idle(1'b0);
		bus(`IDX_SER_CTRL, 1'b1, 8'h10);
		tx.send(8'hc6, 8, 64, 1'b0, 1'b0, 1, 1'b1);
		expect_reg(`IDX_RX_HOLD, "inverted", 8'hc6);
		clear_flags();
		bus(`IDX_SER_CTRL, 1'b1, 8'h00);
		bus(`IDX_PORT_CTRL, 1'b1, 8'h00);
		tx.set_idle(1'b1);
	endtask

	task automatic t_rate();
		setup(8'h00, 8'h04, 8'h10);
		tx.send(8'hc3, 8, 320, 1'b0, 1'b0, 1, 1'b1);
		expect_reg(`IDX_RX_HOLD, "div 4", 8'hc3);
		clear_flags();
		setup(8'h02, 8'h00, 8'h10);
		tx.send(8'h5e, 8, 1024, 1'b0, 1'b0, 1, 1'b1);
		expect_reg(`IDX_RX_HOLD, "prescale 16", 8'h5e);
		clear_flags();
		setup(8'h01, 8'h01, 8'h10);
		tx.send(8'h81, 8, 512, 1'b0, 1'b0, 1, 1'b1);
		expect_reg(`IDX_RX_HOLD, "prescale", 8'h81);
		clear_flags();
		repeat (2) @(posedge hclk);
		check("clk pin oe", 8'h00, {7'h00, clk_oe});
		bus(`IDX_SER_CTRL, 1'b1, 8'h11);
		repeat (2) @(posedge hclk);
		check("clk pin oe", 8'h01, {7'h00, clk_oe});
		clk_was = clk_out;
		repeat (256) @(posedge hclk);
		check("clk pin out", {7'h00, ~clk_was}, {7'h00, clk_out});
	endtask

	task automatic t_freeze();
		ce <= 1'b0;
		repeat (4) @(posedge hclk);
		check("ready frozen", 8'h00, {7'h00, hreadyout});
		ce <= 1'b1;
		@(posedge hclk);
		check("ready run", 8'h01, {7'h00, hreadyout});
	endtask

	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_freeze();
		t_basic();
		t_overrun();
		t_format();
		t_off();
		t_invert();
		t_rate();
		summarize();
	end
endmodule

`default_nettype wire
